/* core/rx_timing_pkg.sv */
// timing modes, clock sources, report kinds and timing constants for the loss monitor
package rx_timing_pkg;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        sync_timing,
        async_timing,
        derived_timing,
        pseudoternary_timing
    } tmode_e;

    typedef enum logic [1:0] {
        frequency_synthesizer_source,
        interface_module_source,
        external_connector_source
    } tx_src_e;

    typedef enum logic [1:0] {
        rpt_data_loss,
        rpt_clock_loss,
        rpt_sync_loss
    } rpt_kind_e;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 4;
    localparam int CLK_LOSS_TIME_MS = 50;
    localparam int CLK_LOSS_CYCLES = CLK_LOSS_TIME_MS * 1000000 / MCLK_PERIOD_NS;

    // ------------------------------------------------------------
    // rates and character framing
    // ------------------------------------------------------------
    localparam logic [31:0] ASYNC_MIN_BPS = 32'h0000_0032;
    localparam logic [31:0] ASYNC_MAX_BPS = 32'h0000_4E20;
    localparam logic [31:0] DERIVED_MAX_BPS = 32'h0007_EF40;
    localparam int EXT_CLK_MULT = 16;
    localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
    localparam logic [3:0] CHAR_BITS_MAX = 4'h8;

    // ------------------------------------------------------------
    // synchronised pin indices
    // ------------------------------------------------------------
    localparam int PIN_RT = 0;
    localparam int PIN_TT = 1;
    localparam int PIN_ST = 2;
    localparam int PIN_INTERFACE_MODULE_SOURCE = 3;
    localparam int PIN_EXT = 4;
    localparam int PIN_FREQUENCY_SYNTHESIZER_SOURCE = 5;
    localparam int PIN_RECOV = 6;
    localparam int NUM_PINS = 7;

endpackage

/* core/rx_timing_select_loss_monitor.sv */
// timing-mode selection, clock source selection and receive loss monitoring
`timescale 1ns/1ps

module rx_timing_select_loss_monitor
    import rx_timing_pkg::*;
#(
    parameter int LOSS_CYCLES = CLK_LOSS_CYCLES,
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // clock pins from the link and the clock sources
    input wire logic rcv_timing_pin,
    input wire logic tt_pin,
    input wire logic st_pin,
    input wire logic interface_module_source_clk_pin,
    input wire logic external_transmit_clock_input,
    input wire logic frequency_synthesizer_source_clk_pin,
    input wire logic recovered_clk_pin,
    // configuration
    input wire logic dce_mode,
    input wire logic pseudoternary_interface_module_source,
    input wire logic interface_module_source_sync_ok,
    input wire logic interface_module_source_async_ok,
    input wire logic interface_module_source_derived_ok,
    input wire logic recovery_installed,
    input wire logic mode_step,
    input wire tx_src_e transmit_clock_source_select,
    input wire logic rcv_clk_force_en,
    input wire logic rcv_clk_force_tt,
    input wire logic [31:0] frequency_synthesizer_source_rate_bps,
    input wire logic [3:0] char_bits,
    // loss events from the analysers, test restart and manual clear
    input wire logic data_loss_evt,
    input wire logic error_loss_evt,
    input wire logic test_restart,
    input wire logic manual_clear,
    // report enables
    input wire logic printer_on,
    input wire logic msg_en_data,
    input wire logic msg_en_clock,
    input wire logic msg_en_sync,
    // report stream
    output logic rpt_valid,
    input wire logic rpt_ready,
    output rpt_kind_e rpt_kind,
    output logic [CNT_W-1:0] rpt_count,
    // status
    output tmode_e timing_mode,
    output logic rx_clk_out,
    output logic tx_clk_out,
    output logic gen_bit_tick,
    output logic clock_lost,
    output logic sync_lost,
    output logic [CNT_W-1:0] data_loss_count,
    output logic [CNT_W-1:0] clock_loss_count,
    output logic [CNT_W-1:0] sync_loss_count,
    output logic rate_ok,
    output logic src_ok,
    output logic frame_ok,
    output logic split_rate_ok
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int TW = $clog2(LOSS_CYCLES + 2);
    localparam logic [TW-1:0] LIM = TW'(LOSS_CYCLES);
    localparam logic [TW-1:0] LIM1 = TW'(LOSS_CYCLES + 1);
    localparam logic [CNT_W-1:0] CMAX = '1;
    localparam logic [3:0] DIV_LAST = 4'(EXT_CLK_MULT - 1);

    typedef struct packed {
        logic [NUM_PINS-1:0] sy1;
        logic [NUM_PINS-1:0] sy2;
        logic [NUM_PINS-1:0] sy3;
        logic [TW-1:0] loss_cnt;
        logic [TW-1:0] tt_cnt;
        logic [3:0] ext_div;
        tmode_e mode;
        logic rx_clk;
        logic tx_clk;
        logic bit_tick;
        logic clk_lost;
        logic [CNT_W-1:0] data_cnt;
        logic [CNT_W-1:0] clk_cnt;
        logic [CNT_W-1:0] sync_cnt;
        logic lock_dropped;
        logic pend_data;
        logic pend_clk;
        logic pend_sync;
        logic rvalid;
        rpt_kind_e rkind;
        logic [CNT_W-1:0] rcount;
        logic rate_good;
        logic src_good;
        logic frame_good;
        logic split_good;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic [NUM_PINS-1:0] fall;
    logic [NUM_PINS-1:0] rise;
    logic [3:0] mode_ok;
    logic tt_active;
    logic use_tt;
    int mon_pin;
    logic clk_loss_evt;
    logic sync_loss_evt;
    logic rx_clk_sel;
    tx_src_e eff_src;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] sat_inc(logic [CNT_W-1:0] v);
        sat_inc = (v == CMAX) ? v : v + 1'h1;
    endfunction

    function automatic tmode_e step_mode(tmode_e cur, logic [3:0] ok);
        tmode_e m;
        tmode_e res;
        logic found;
        m = cur;
        res = cur;
        found = 1'h0;
        for (int i = 0; i < 3; i++) begin
            unique case (m)
                sync_timing: m = async_timing;
                async_timing: m = derived_timing;
                derived_timing: m = sync_timing;
                pseudoternary_timing: m = sync_timing;
            endcase
            if (!found && ok[m]) begin
                res = m;
                found = 1'h1;
            end
        end
        step_mode = res;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sy1 = {recovered_clk_pin, frequency_synthesizer_source_clk_pin, external_transmit_clock_input,
                   interface_module_source_clk_pin, st_pin, tt_pin, rcv_timing_pin};
        s_d.sy2 = s_q.sy1;
        s_d.sy3 = s_q.sy2;
        fall = s_q.sy3 & ~s_q.sy2;
        rise = ~s_q.sy3 & s_q.sy2;

        // timing selector
        mode_ok = {1'h0, interface_module_source_derived_ok & recovery_installed, interface_module_source_async_ok, interface_module_source_sync_ok};
        if (pseudoternary_interface_module_source) begin
            s_d.mode = pseudoternary_timing;
        end else if (!mode_ok[s_q.mode] || mode_step) begin
            s_d.mode = step_mode(s_q.mode, mode_ok);
        end

        // receive clock choice
        if (fall[PIN_TT]) begin
            s_d.tt_cnt = '0;
        end else if (s_q.tt_cnt != LIM1) begin
            s_d.tt_cnt = s_q.tt_cnt + 1'h1;
        end
        tt_active = (s_q.tt_cnt <= LIM);
        use_tt = rcv_clk_force_en ? rcv_clk_force_tt : tt_active;
        mon_pin = dce_mode ? (use_tt ? PIN_TT : PIN_ST) : PIN_RT;

        // clock absence timer
        clk_loss_evt = 1'h0;
        if (s_q.mode != sync_timing) begin
            s_d.loss_cnt = '0;
        end else if (fall[mon_pin]) begin
            s_d.loss_cnt = '0;
        end else if (s_q.loss_cnt != LIM1) begin
            s_d.loss_cnt = s_q.loss_cnt + 1'h1;
            clk_loss_evt = (s_q.loss_cnt == LIM);
        end
        s_d.clk_lost = (s_d.loss_cnt == LIM1);

        // receiver clock
        unique case (s_q.mode)
            sync_timing: rx_clk_sel = s_q.sy2[mon_pin];
            async_timing: rx_clk_sel = s_q.sy2[PIN_FREQUENCY_SYNTHESIZER_SOURCE];
            derived_timing: rx_clk_sel = s_q.sy2[PIN_RECOV];
            pseudoternary_timing: rx_clk_sel = s_q.sy2[PIN_RECOV];
        endcase
        s_d.rx_clk = rx_clk_sel;

        // transmit clock
        s_d.src_good = !(s_q.mode == async_timing &&
                         transmit_clock_source_select == interface_module_source);
        eff_src = s_d.src_good ? transmit_clock_source_select : frequency_synthesizer_source;
        unique case (eff_src)
            frequency_synthesizer_source: s_d.tx_clk = s_q.sy2[PIN_FREQUENCY_SYNTHESIZER_SOURCE];
            interface_module_source: s_d.tx_clk = dce_mode ? rx_clk_sel : s_q.sy2[PIN_INTERFACE_MODULE_SOURCE];
            external_connector_source: s_d.tx_clk = s_q.sy2[PIN_EXT];
            default: s_d.tx_clk = s_q.sy2[PIN_FREQUENCY_SYNTHESIZER_SOURCE];
        endcase

        // external 16x divider for asynchronous generation
        s_d.bit_tick = 1'h0;
        if (rise[PIN_EXT]) begin
            s_d.ext_div = s_q.ext_div + 1'h1;
            s_d.bit_tick = (s_q.ext_div == DIV_LAST) && (s_q.mode == async_timing) &&
                           (eff_src == external_connector_source);
        end

        // configuration checks
        unique case (s_q.mode)
            async_timing: s_d.rate_good = (frequency_synthesizer_source_rate_bps >= ASYNC_MIN_BPS) &&
                                          (frequency_synthesizer_source_rate_bps <= ASYNC_MAX_BPS);
            derived_timing: s_d.rate_good = (frequency_synthesizer_source_rate_bps < DERIVED_MAX_BPS);
            default: s_d.rate_good = 1'h1;
        endcase
        s_d.frame_good = (s_q.mode != async_timing) ||
                         (char_bits >= CHAR_BITS_MIN && char_bits <= CHAR_BITS_MAX);
        s_d.split_good = (s_q.mode == async_timing) &&
                         (eff_src == external_connector_source);

        // loss counters, restart first so that a same-cycle event still counts
        sync_loss_evt = data_loss_evt | clk_loss_evt | error_loss_evt;
        if (test_restart) begin
            s_d.data_cnt = '0;
            s_d.clk_cnt = '0;
            s_d.sync_cnt = '0;
        end
        if (data_loss_evt) begin
            s_d.data_cnt = sat_inc(s_d.data_cnt);
        end
        if (clk_loss_evt) begin
            s_d.clk_cnt = sat_inc(s_d.clk_cnt);
        end
        if (sync_loss_evt) begin
            s_d.sync_cnt = sat_inc(s_d.sync_cnt);
        end

        // sticky lock-dropped flag, set wins over clear
        if (test_restart || manual_clear) begin
            s_d.lock_dropped = 1'h0;
        end
        if (sync_loss_evt) begin
            s_d.lock_dropped = 1'h1;
        end

        // report stream: cause report ahead of its sync report
        if (rpt_ready || !s_q.rvalid) begin
            s_d.rvalid = 1'h0;
            if (s_q.pend_data) begin
                s_d.rvalid = 1'h1;
                s_d.rkind = rpt_data_loss;
                s_d.rcount = s_q.data_cnt;
                s_d.pend_data = 1'h0;
            end else if (s_q.pend_clk) begin
                s_d.rvalid = 1'h1;
                s_d.rkind = rpt_clock_loss;
                s_d.rcount = s_q.clk_cnt;
                s_d.pend_clk = 1'h0;
            end else if (s_q.pend_sync) begin
                s_d.rvalid = 1'h1;
                s_d.rkind = rpt_sync_loss;
                s_d.rcount = s_q.sync_cnt;
                s_d.pend_sync = 1'h0;
            end
        end
        if (data_loss_evt && printer_on && msg_en_data) begin
            s_d.pend_data = 1'h1;
        end
        if (clk_loss_evt && printer_on && msg_en_clock) begin
            s_d.pend_clk = 1'h1;
        end
        if (sync_loss_evt && printer_on && msg_en_sync) begin
            s_d.pend_sync = 1'h1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rpt_valid = s_q.rvalid;
    assign rpt_kind = s_q.rkind;
    assign rpt_count = s_q.rcount;
    assign timing_mode = s_q.mode;
    assign rx_clk_out = s_q.rx_clk;
    assign tx_clk_out = s_q.tx_clk;
    assign gen_bit_tick = s_q.bit_tick;
    assign clock_lost = s_q.clk_lost;
    assign sync_lost = s_q.lock_dropped;
    assign data_loss_count = s_q.data_cnt;
    assign clock_loss_count = s_q.clk_cnt;
    assign sync_loss_count = s_q.sync_cnt;
    assign rate_ok = s_q.rate_good;
    assign src_ok = s_q.src_good;
    assign frame_ok = s_q.frame_good;
    assign split_rate_ok = s_q.split_good;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence clk_loss_seen;
        clk_loss_evt && !test_restart;
    endsequence

    sequence clk_rpt_sent;
        s_q.rvalid && rpt_ready && s_q.rkind == rpt_clock_loss && s_q.pend_sync;
    endsequence

    loss_timeout_a: assert property (@(posedge mclk) disable iff (rst)
        s_q.mode == sync_timing && s_q.loss_cnt == LIM && !fall[mon_pin]
        |=> s_q.clk_lost)
        else $error("clock loss not declared at limit");

    timer_restart_a: assert property (@(posedge mclk) disable iff (rst)
        s_q.mode == sync_timing && fall[mon_pin] |=> s_q.loss_cnt == '0 && !s_q.clk_lost)
        else $error("absence timer not restarted");

    clk_tally_a: assert property (@(posedge mclk) disable iff (rst)
        clk_loss_seen ##0 (s_q.clk_cnt != CMAX)
        |=> s_q.clk_cnt == $past(s_q.clk_cnt) + 1'h1)
        else $error("clock tally not incremented");

    report_order_a: assert property (@(posedge mclk) disable iff (rst)
        clk_rpt_sent ##0 !s_q.pend_data |=> s_q.rvalid && s_q.rkind == rpt_sync_loss)
        else $error("sync report did not follow clock report");

    sticky_flag_a: assert property (@(posedge mclk) disable iff (rst)
        sync_loss_evt |=> s_q.lock_dropped ##1 (s_q.lock_dropped || $past(test_restart)
        || $past(manual_clear)))
        else $error("lock-dropped flag not sticky");

    sync_count_a: assert property (@(posedge mclk) disable iff (rst)
        data_loss_evt && !test_restart && s_q.sync_cnt < CMAX
        |=> s_q.sync_cnt == $past(s_q.sync_cnt) + 1'h1)
        else $error("data loss did not count as sync loss");

    sync_gate_a: assert property (@(posedge mclk) disable iff (rst)
        sync_loss_evt && !(printer_on && msg_en_sync) && !s_q.pend_sync
        |=> !s_q.pend_sync)
        else $error("sync report queued while disabled");

    derived_ignore_a: assert property (@(posedge mclk) disable iff (rst)
        s_q.mode == derived_timing |-> !clk_loss_evt ##1 s_q.loss_cnt == '0)
        else $error("receive clock watched in derived timing");

    pseudo_lock_a: assert property (@(posedge mclk) disable iff (rst)
        pseudoternary_interface_module_source[*2] |-> s_q.mode == pseudoternary_timing)
        else $error("selector active on pseudoternary interface");

    no_recovery_a: assert property (@(posedge mclk) disable iff (rst)
        !recovery_installed && !pseudoternary_interface_module_source && (interface_module_source_sync_ok || interface_module_source_async_ok)
        |=> s_q.mode != derived_timing)
        else $error("derived timing offered without recovery");

    restart_clear_a: assert property (@(posedge mclk) disable iff (rst)
        test_restart && !sync_loss_evt |=> s_q.sync_cnt == '0 && !s_q.lock_dropped)
        else $error("restart did not clear");

endmodule

/* verification/link_partner_model.sv */
// far-side equipment model driving the receive clock leads
`timescale 1ns/1ps
module link_partner_model #(
    parameter int HALF_NS = 16
) (
    // lead enables from the bench
    input wire logic rt_en,
    input wire logic tt_en,
    input wire logic st_en,
    // clock leads
    output logic rt_lead,
    output logic tt_lead,
    output logic st_lead
);
    // ------------------------------------------------------------
    // one bit clock shared by every lead, idle high when stopped
    // ------------------------------------------------------------
    logic base = 1'b1;
    always #(HALF_NS) base = ~base;
    assign rt_lead = rt_en ? base : 1'b1;
    assign tt_lead = tt_en ? base : 1'b1;
    assign st_lead = st_en ? base : 1'b1;
endmodule

/* verification/rx_timing_select_loss_monitor_tb.sv */
// self-checking bench for the timing selector and loss monitor
`timescale 1ns/1ps
module rx_timing_select_loss_monitor_tb;
    import rx_timing_pkg::*;
    localparam int LOSS_N = 40;
    localparam int CW = 4;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic mclk = 1'b0, rst = 1'b1, aux_clk = 1'b0;
    logic rt_en = 1'b1, tt_en = 1'b1, st_en = 1'b1, rt_lead, tt_lead, st_lead;
    logic dce_mode = 1'b0, pseudo_interface_module_source = 1'b0, ok_sync = 1'b1, ok_async = 1'b1;
    logic ok_derived = 1'b1, recov_inst = 1'b1, mode_step = 1'b0;
    logic force_en = 1'b0, force_tt = 1'b0, data_evt = 1'b0, err_evt = 1'b0;
    logic restart = 1'b0, man_clear = 1'b0, printer_on = 1'b1;
    logic en_data = 1'b1, en_clock = 1'b1, en_sync = 1'b1, rpt_ready = 1'b1;
    tx_src_e src_sel = frequency_synthesizer_source;
    logic [31:0] frequency_synthesizer_source_rate = 32'h0000_2580;
    logic [3:0] char_bits = 4'h8;
    logic rpt_valid, rx_clk_out, tx_clk_out, gen_bit_tick, clock_lost, sync_lost;
    logic rate_ok, src_ok, frame_ok, split_rate_ok;
    rpt_kind_e rpt_kind;
    tmode_e timing_mode;
    logic [CW-1:0] rpt_count, data_cnt, clock_cnt, sync_cnt;
    logic [1:0] q_kind [$];
    logic [CW-1:0] q_cnt [$];
    int bad_count = 0, n_compared = 0, cycles = 0;
    int tick_count = 0, tx_rise = 0, rx_rise = 0;
    logic tx_seen = 1'b0, rx_seen = 1'b0;
    always #2 mclk = ~mclk;
    always #12 aux_clk = ~aux_clk;
    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    rx_timing_select_loss_monitor #(.LOSS_CYCLES(LOSS_N), .CNT_W(CW)) u_dut (
        .mclk(mclk), .rst(rst), .rcv_timing_pin(rt_lead), .tt_pin(tt_lead), .st_pin(st_lead),
        .interface_module_source_clk_pin(aux_clk), .external_transmit_clock_input(aux_clk),
        .frequency_synthesizer_source_clk_pin(aux_clk), .recovered_clk_pin(aux_clk), .dce_mode(dce_mode),
        .pseudoternary_interface_module_source(pseudo_interface_module_source), .interface_module_source_sync_ok(ok_sync), .interface_module_source_async_ok(ok_async),
        .interface_module_source_derived_ok(ok_derived), .recovery_installed(recov_inst), .mode_step(mode_step),
        .transmit_clock_source_select(src_sel), .rcv_clk_force_en(force_en),
        .rcv_clk_force_tt(force_tt), .frequency_synthesizer_source_rate_bps(frequency_synthesizer_source_rate), .char_bits(char_bits),
        .data_loss_evt(data_evt), .error_loss_evt(err_evt), .test_restart(restart),
        .manual_clear(man_clear), .printer_on(printer_on), .msg_en_data(en_data),
        .msg_en_clock(en_clock), .msg_en_sync(en_sync), .rpt_valid(rpt_valid),
        .rpt_ready(rpt_ready), .rpt_kind(rpt_kind), .rpt_count(rpt_count),
        .timing_mode(timing_mode), .rx_clk_out(rx_clk_out), .tx_clk_out(tx_clk_out),
        .gen_bit_tick(gen_bit_tick), .clock_lost(clock_lost), .sync_lost(sync_lost),
        .data_loss_count(data_cnt), .clock_loss_count(clock_cnt), .sync_loss_count(sync_cnt),
        .rate_ok(rate_ok), .src_ok(src_ok), .frame_ok(frame_ok), .split_rate_ok(split_rate_ok)
    );
    link_partner_model u_far (.rt_en(rt_en), .tt_en(tt_en), .st_en(st_en),
        .rt_lead(rt_lead), .tt_lead(tt_lead), .st_lead(st_lead));
    // ------------------------------------------------------------
    // report capture, timeout and helpers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rpt_valid === 1'b1 && rpt_ready === 1'b1) begin
            q_kind.push_back(rpt_kind);
            q_cnt.push_back(rpt_count);
        end
        if (tx_clk_out === 1'b1 && tx_seen === 1'b0) begin
            tx_rise++;
        end
        if (rx_clk_out === 1'b1 && rx_seen === 1'b0) begin
            rx_rise++;
        end
        if (gen_bit_tick === 1'b1) begin
            tick_count++;
        end
        tx_seen = tx_clk_out;
        rx_seen = rx_clk_out;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pulse_step();
        mode_step = 1'b1;
        step(1);
        mode_step = 1'b0;
        step(3);
    endtask
    task automatic expect_rpt(input logic [1:0] kind, input logic [CW-1:0] cnt);
        if (q_kind.size() == 0) begin
            chk("report present", 1, 0);
        end else begin
            chk("report kind", kind, q_kind.pop_front());
            chk("report count", cnt, q_cnt.pop_front());
        end
    endtask
    task automatic wait_lost(input logic want, input int lim);
        int i;
        for (i = 0; i < lim && clock_lost !== want; i++) begin
            step(1);
        end
        chk("clock_lost", want, clock_lost);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int i, j, k;
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        step(2);
        chk("sync count", 0, sync_cnt);
        chk("mode", sync_timing, timing_mode);
        rpt_ready = 1'b0;
        data_evt = 1'b1;
        step(1);
        data_evt = 1'b0;
        step(5);
        chk("data count", 1, data_cnt);
        chk("sync count", 1, sync_cnt);
        chk("sync_lost", 1, sync_lost);
        chk("held valid", 1, rpt_valid);
        chk("held kind", rpt_data_loss, rpt_kind);
        rpt_ready = 1'b1;
        step(4);
        expect_rpt(rpt_data_loss, 1);
        expect_rpt(rpt_sync_loss, 1);
        man_clear = 1'b1;
        step(1);
        man_clear = 1'b0;
        step(3);
        chk("sync_lost", 0, sync_lost);
        chk("data count", 1, data_cnt);
        tt_en = 1'b0;
        rt_en = 1'b0;
        step(LOSS_N - 10);
        chk("early loss", 0, clock_lost);
        wait_lost(1'b1, 40);
        step(4);
        chk("clock count", 1, clock_cnt);
        chk("sync count", 2, sync_cnt);
        chk("sync_lost", 1, sync_lost);
        expect_rpt(rpt_clock_loss, 1);
        expect_rpt(rpt_sync_loss, 2);
        rt_en = 1'b1;
        wait_lost(1'b0, 20);
        dce_mode = 1'b1;
        step(3 * LOSS_N);
        chk("st fallback", 0, clock_lost);
        force_en = 1'b1;
        force_tt = 1'b1;
        wait_lost(1'b1, LOSS_N + 20);
        force_en = 1'b0;
        wait_lost(1'b0, 20);
        chk("clock count", 2, clock_cnt);
        expect_rpt(rpt_clock_loss, 2);
        expect_rpt(rpt_sync_loss, 3);
        dce_mode = 1'b0;
        pulse_step();
        chk("mode", async_timing, timing_mode);
        pulse_step();
        chk("mode", derived_timing, timing_mode);
        rt_en = 1'b0;
        step(LOSS_N + 30);
        chk("derived ignores clock", 0, clock_lost);
        rt_en = 1'b1;
        frequency_synthesizer_source_rate = 32'h0007_EF3F;
        step(3);
        chk("derived rate", 1, rate_ok);
        frequency_synthesizer_source_rate = 32'h0007_EF40;
        step(3);
        chk("derived rate", 0, rate_ok);
        pulse_step();
        chk("mode", sync_timing, timing_mode);
        recov_inst = 1'b0;
        pulse_step();
        pulse_step();
        chk("skip derived", sync_timing, timing_mode);
        recov_inst = 1'b1;
        ok_sync = 1'b0;
        ok_derived = 1'b0;
        step(3);
        chk("sole mode", async_timing, timing_mode);
        pulse_step();
        chk("frozen", async_timing, timing_mode);
        for (i = 0; i < 4; i++) begin
            frequency_synthesizer_source_rate = (i < 2) ? 32'h0000_0031 + i : 32'h0000_4E1E + i;
            char_bits = 4'((i < 2) ? 4 + i : 6 + i);
            step(3);
            chk("async rate", (i == 1 || i == 2), rate_ok);
            chk("char bits", (i == 1 || i == 2), frame_ok);
        end
        src_sel = interface_module_source;
        step(3);
        chk("interface_module_source src", 0, src_ok);
        src_sel = external_connector_source;
        step(3);
        chk("split rate", 1, split_rate_ok);
        i = tick_count;
        j = tx_rise;
        k = rx_rise;
        step(192);
        chk("bit ticks", i + 2, tick_count);
        chk("tx clock edges", j + 32, tx_rise);
        chk("rx clock edges", k + 32, rx_rise);
        pseudo_interface_module_source = 1'b1;
        step(3);
        pulse_step();
        chk("pseudo", pseudoternary_timing, timing_mode);
        restart = 1'b1;
        step(1);
        restart = 1'b0;
        step(3);
        chk("clock count", 0, clock_cnt);
        chk("sync_lost", 0, sync_lost);
        en_sync = 1'b0;
        err_evt = 1'b1;
        step(17);
        printer_on = 1'b0;
        en_sync = 1'b1;
        step(3);
        err_evt = 1'b0;
        step(4);
        chk("saturate", 15, sync_cnt);
        chk("data count", 0, data_cnt);
        chk("no reports", 0, q_kind.size());
        stop_test();
    end
endmodule
